/* src/mem_map_pkg.sv */
// Functional notes
// (RQ1) Program counter is 13 bits, addressing 8K words of 14 bits.
// (RQ2) Reduced variant keeps 4K words; fetch addresses wrap, upper bit ignored.
// (RQ3) Fetch starts at 0000h after reset; interrupt redirects to 0004h.
// (RQ4) Bank bits at flags 6:5 select one of four 128-location banks.
// (RQ5) Special registers sit low in each bank, static RAM above them.
// (RQ6) Frequently used special registers are mirrored across banks.
// (RQ7) Top 16 locations of banks 1-3 alias bank-0 70h-7Fh.
// (RQ8) Register file reached directly or indirectly via file select pointer.
// (RQ9) Offset 00h accesses the location addressed by the file select pointer.
// (RQ10) Unimplemented data addresses read zero; writes are ignored.
package mem_map_pkg;
	localparam int PC_W = 13;
	localparam int DADDR_W = 9;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] INT_VECTOR = 13'h0004;
	localparam logic [6:0] OFS_INDIRECT = 7'h00;
	localparam logic [6:0] OFS_PCL = 7'h02;
	localparam logic [6:0] OFS_FLAGS = 7'h03;
	localparam logic [6:0] OFS_FSR = 7'h04;
	localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0a;
	localparam logic [6:0] GPR_LO = 7'h20;
	localparam logic [6:0] COMMON_LO = 7'h70;
	localparam int BANK_HI_BIT = 6;
	localparam int BANK_LO_BIT = 5;
	localparam logic [7:0] FLAGS_RESET = 8'h18;
	localparam logic [7:0] ZERO8 = 8'h00;
endpackage : mem_map_pkg

/* src/memory_map_bank_decoder.sv */
module memory_map_bank_decoder
	import mem_map_pkg::*;
#(
	parameter bit REDUCED = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Program fetch control
	input wire logic pc_advance,
	input wire logic pc_load,
	input wire logic [10:0] pc_load_value,
	input wire logic int_accept,
	output logic [12:0] fetch_addr,
	// Data access
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	logic [12:0] pc;
	logic [12:0] next_pc;
	logic [7:0] pc_high_latch;
	logic [7:0] processor_flags;
	logic [7:0] file_select_pointer;
	logic [7:0] ram [0:255];
	always_comb begin
		next_pc = pc;
		if (int_accept) begin
			next_pc = INT_VECTOR; // RQ3
		end else if (pc_load) begin
			next_pc = {pc_high_latch[4:3], pc_load_value}; // RQ1
		end else if (pc_advance) begin
			next_pc = pc + 13'h0001; // RQ1
		end
		if (REDUCED) begin
			next_pc[12] = 1'b0; // RQ2
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pc <= RESET_VECTOR; // RQ3
		end else begin
			pc <= next_pc;
		end
	end
	assign fetch_addr = pc;
	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [8:0] eff;
	logic [6:0] ofs;
	logic [1:0] bank;
	logic in_common;
	logic is_gpr;
	logic [7:0] ram_idx;
	always_comb begin
		// Offset 00h follows the pointer, flags bit 7 as address bit 8
		if (addr == OFS_INDIRECT) begin
			eff = {processor_flags[7], file_select_pointer}; // RQ8 RQ9
		end else begin
			eff = {processor_flags[BANK_HI_BIT], processor_flags[BANK_LO_BIT], addr}; // RQ4 RQ8
		end
		ofs = eff[6:0];
		bank = eff[8:7];
		in_common = (ofs >= COMMON_LO); // RQ7
	end

	always_comb begin
		is_gpr = 1'b0;
		ram_idx = {1'b0, ofs};
		if (in_common) begin
			// Top 16 locations of every bank land on bank 0
			is_gpr = 1'b1; // RQ7
			ram_idx = {1'b0, ofs}; // RQ7
		end else if (ofs >= GPR_LO) begin
			unique case (bank)
				2'b00: begin
					is_gpr = 1'b1; // RQ5
					ram_idx = {1'b0, ofs};
				end
				2'b01: begin
					is_gpr = 1'b1; // RQ5
					ram_idx = {1'b1, ofs};
				end
				2'b10: begin
					// Bank 2 fills the index gaps left by banks 0 and 1
					is_gpr = 1'b1; // RQ5
					if (ofs < 7'h40) begin
						ram_idx = {1'b0, ofs ^ 7'h20};
					end else if (ofs < 7'h60) begin
						ram_idx = {1'b1, ofs ^ 7'h40};
					end else begin
						ram_idx = {1'b1, ofs ^ 7'h10};
					end
				end
				2'b11: begin
					// No static RAM below the common window
					is_gpr = 1'b0; // RQ10
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register select
	// ----------------------------------------
	logic live;
	logic sel_pcl;
	logic sel_flags;
	logic sel_fsr;
	logic sel_pc_high_latch;
	logic rd_live;
	logic wr_live;
	always_comb begin
		// Pointer aimed at the indirect slot reaches nothing
		live = (ofs != OFS_INDIRECT); // RQ9
		sel_pcl = live && (ofs == OFS_PCL); // RQ6
		sel_flags = live && (ofs == OFS_FLAGS); // RQ6
		sel_fsr = live && (ofs == OFS_FSR); // RQ6
		sel_pc_high_latch = live && (ofs == OFS_PC_HIGH_LATCH); // RQ6
		rd_live = rd && live;
		wr_live = wr && live;
	end
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] next_rdata;
	logic [7:0] next_processor_flags;
	logic [7:0] next_file_select_pointer;
	logic [7:0] next_pc_high_latch;

	always_comb begin
		next_rdata = ZERO8; // RQ10
		if (rd_live) begin
			unique case (ofs)
				OFS_PCL: next_rdata = pc[7:0]; // RQ6
				OFS_FLAGS: next_rdata = processor_flags; // RQ6
				OFS_FSR: next_rdata = file_select_pointer; // RQ6
				OFS_PC_HIGH_LATCH: next_rdata = pc_high_latch; // RQ6
				default: next_rdata = is_gpr ? ram[ram_idx] : ZERO8; // RQ10
			endcase
		end
	end

	always_comb begin
		next_processor_flags = processor_flags;
		next_file_select_pointer = file_select_pointer;
		next_pc_high_latch = pc_high_latch;
		if (wr_live) begin
			if (sel_flags) begin
				next_processor_flags = wdata; // RQ4 RQ6
			end
			if (sel_fsr) begin
				next_file_select_pointer = wdata; // RQ6 RQ8
			end
			if (sel_pc_high_latch) begin
				next_pc_high_latch = wdata; // RQ6
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata <= ZERO8;
			processor_flags <= FLAGS_RESET;
			file_select_pointer <= ZERO8;
			pc_high_latch <= ZERO8;
		end else begin
			rdata <= next_rdata;
			processor_flags <= next_processor_flags;
			file_select_pointer <= next_file_select_pointer;
			pc_high_latch <= next_pc_high_latch;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_live && is_gpr) begin
			ram[ram_idx] <= wdata; // RQ5 RQ10
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_reset_vec;
		@(posedge ref_clk) $fell(rst) |-> pc == RESET_VECTOR;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("bad reset vector"); // RQ3
	property p_int_vec;
		@(posedge ref_clk) disable iff (rst) int_accept |=> pc == INT_VECTOR;
	endproperty
	a_int_vec: assert property (p_int_vec) else $error("bad interrupt vector"); // RQ3
	property p_wrap;
		@(posedge ref_clk) disable iff (rst) REDUCED |-> pc[12] == 1'b0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("reduced pc above 4K"); // RQ2
	property p_inc;
		@(posedge ref_clk) disable iff (rst)
			pc_advance && !pc_load && !int_accept && !REDUCED |=> pc == $past(pc) + 13'h0001;
	endproperty
	a_inc: assert property (p_inc) else $error("pc did not advance"); // RQ1
	property p_fsr_mirror;
		@(posedge ref_clk) disable iff (rst) rd && addr == OFS_FSR |=> rdata == file_select_pointer;
	endproperty
	a_fsr_mirror: assert property (p_fsr_mirror) else $error("pointer not mirrored"); // RQ6
	property p_idle_zero;
		@(posedge ref_clk) disable iff (rst) !rd |=> rdata == ZERO8;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data not zero"); // RQ10
	property p_sfr_low;
		@(posedge ref_clk) disable iff (rst) addr < GPR_LO && addr != OFS_INDIRECT |-> !is_gpr;
	endproperty
	a_sfr_low: assert property (p_sfr_low) else $error("ram in sfr area"); // RQ5
	property p_common;
		@(posedge ref_clk) disable iff (rst) ofs >= COMMON_LO |-> ram_idx[7] == 1'b0;
	endproperty
	a_common: assert property (p_common) else $error("common area not aliased"); // RQ7

	// ----------------------------------------
	// Data path checks
	// ----------------------------------------
	property p_flags_write;
		@(posedge ref_clk) disable iff (rst) wr && addr == OFS_FLAGS |=> processor_flags == $past(wdata);
	endproperty
	a_flags_write: assert property (p_flags_write) else $error("flags write lost"); // RQ4

	property p_fsr_write;
		@(posedge ref_clk) disable iff (rst)
			wr && addr == OFS_FSR |=> file_select_pointer == $past(wdata);
	endproperty
	a_fsr_write: assert property (p_fsr_write) else $error("pointer write lost"); // RQ8

	property p_pc_high_latch_write;
		@(posedge ref_clk) disable iff (rst)
			wr && addr == OFS_PC_HIGH_LATCH |=> pc_high_latch == $past(wdata);
	endproperty
	a_pc_high_latch_write: assert property (p_pc_high_latch_write) else $error("latch write lost"); // RQ6

	property p_bank_sel;
		@(posedge ref_clk) disable iff (rst)
			addr != OFS_INDIRECT |-> bank == {processor_flags[BANK_HI_BIT], processor_flags[BANK_LO_BIT]};
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("bank not from flags"); // RQ4

	property p_ind_addr;
		@(posedge ref_clk) disable iff (rst)
			addr == OFS_INDIRECT |-> eff == {processor_flags[7], file_select_pointer};
	endproperty
	a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong"); // RQ9

	property p_ind_self;
		@(posedge ref_clk) disable iff (rst)
			rd && addr == OFS_INDIRECT && file_select_pointer[6:0] == OFS_INDIRECT |=> rdata == ZERO8;
	endproperty
	a_ind_self: assert property (p_ind_self) else $error("self indirect not zero"); // RQ9

	property p_unimpl_read;
		@(posedge ref_clk) disable iff (rst)
			rd && addr > OFS_PC_HIGH_LATCH && addr < GPR_LO |=> rdata == ZERO8;
	endproperty
	a_unimpl_read: assert property (p_unimpl_read) else $error("empty slot not zero"); // RQ10

	property p_unimpl_write;
		@(posedge ref_clk) disable iff (rst) wr && addr > OFS_PC_HIGH_LATCH && addr < GPR_LO
			|=> $stable(processor_flags) && $stable(file_select_pointer) && $stable(pc_high_latch);
	endproperty
	a_unimpl_write: assert property (p_unimpl_write) else $error("empty slot write hit"); // RQ10

	property p_bank3_read;
		@(posedge ref_clk) disable iff (rst) rd && addr >= GPR_LO && addr < COMMON_LO
			&& processor_flags[BANK_HI_BIT] && processor_flags[BANK_LO_BIT] |=> rdata == ZERO8;
	endproperty
	a_bank3_read: assert property (p_bank3_read) else $error("bank 3 ram not zero"); // RQ10

	property p_pcl_read;
		@(posedge ref_clk) disable iff (rst) rd && addr == OFS_PCL |=> rdata == $past(pc[7:0]);
	endproperty
	a_pcl_read: assert property (p_pcl_read) else $error("pc low byte read wrong"); // RQ6

	property p_flags_read;
		@(posedge ref_clk) disable iff (rst)
			rd && addr == OFS_FLAGS |=> rdata == $past(processor_flags);
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flags read wrong"); // RQ6

	property p_latch_read;
		@(posedge ref_clk) disable iff (rst)
			rd && addr == OFS_PC_HIGH_LATCH |=> rdata == $past(pc_high_latch);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // RQ6

	property p_gpr_range;
		@(posedge ref_clk) disable iff (rst) is_gpr |-> ofs >= GPR_LO;
	endproperty
	a_gpr_range: assert property (p_gpr_range) else $error("ram below sfr bound"); // RQ5

	property p_bank3_low;
		@(posedge ref_clk) disable iff (rst) bank == 2'b11 && !in_common |-> !is_gpr;
	endproperty
	a_bank3_low: assert property (p_bank3_low) else $error("bank 3 ram present"); // RQ10

	property p_common_idx;
		@(posedge ref_clk) disable iff (rst) in_common |-> ram_idx == {1'b0, ofs};
	endproperty
	a_common_idx: assert property (p_common_idx) else $error("common index wrong"); // RQ7

	property p_bank0_idx;
		@(posedge ref_clk) disable iff (rst) bank == 2'b00 && is_gpr |-> ram_idx == {1'b0, ofs};
	endproperty
	a_bank0_idx: assert property (p_bank0_idx) else $error("bank 0 index wrong"); // RQ4

	// ----------------------------------------
	// Fetch checks
	// ----------------------------------------
	property p_pc_reset;
		@(posedge ref_clk) rst |=> pc == RESET_VECTOR;
	endproperty
	a_pc_reset: assert property (p_pc_reset) else $error("pc not cleared"); // RQ3

	property p_load;
		@(posedge ref_clk) disable iff (rst)
			pc_load && !int_accept |=> pc[10:0] == $past(pc_load_value);
	endproperty
	a_load: assert property (p_load) else $error("pc load low bits wrong"); // RQ1

	property p_load_high;
		@(posedge ref_clk) disable iff (rst)
			pc_load && !int_accept && !REDUCED |=> pc[12:11] == $past(pc_high_latch[4:3]);
	endproperty
	a_load_high: assert property (p_load_high) else $error("pc load high bits wrong"); // RQ1

	property p_reduced_inc;
		@(posedge ref_clk) disable iff (rst) REDUCED && pc_advance && !pc_load && !int_accept
			|=> pc[11:0] == $past(pc[11:0]) + 12'h001;
	endproperty
	a_reduced_inc: assert property (p_reduced_inc) else $error("reduced pc no wrap"); // RQ2

	property p_hold;
		@(posedge ref_clk) disable iff (rst) !pc_advance && !pc_load && !int_accept |=> $stable(pc);
	endproperty
	a_hold: assert property (p_hold) else $error("pc moved while idle"); // RQ1

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	c_int: cover property (@(posedge ref_clk) int_accept);
	c_ind: cover property (@(posedge ref_clk) wr && addr == OFS_INDIRECT);
	c_bank3: cover property (@(posedge ref_clk) rd && bank == 2'b11);
	c_bank2: cover property (@(posedge ref_clk) rd && bank == 2'b10);
	c_load: cover property (@(posedge ref_clk) pc_load);
endmodule : memory_map_bank_decoder

/* tb/core_model.sv */
module core_model (
	// Clock and fetch control
	input wire logic ref_clk,
	output logic pc_advance,
	output logic pc_load,
	output logic [10:0] pc_load_value,
	output logic int_accept
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {pc_advance, pc_load, int_accept, pc_load_value} = '0;
	// One-cycle event: 0 advance, 1 load, 2 interrupt
	task automatic pulse(input int kind, input logic [10:0] v);
		@(posedge ref_clk);
		pc_advance <= (kind == 0);
		pc_load <= (kind == 1);
		int_accept <= (kind == 2);
		pc_load_value <= v;
		@(posedge ref_clk);
		{pc_advance, pc_load, int_accept} <= 3'b000;
		pc_load_value <= ~v;
	endtask : pulse
endmodule : core_model

/* tb/tb_top.sv */
module tb_top;
	import mem_map_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, wr = 0, rd = 0, pc_advance, pc_load, int_accept;
	logic [10:0] pc_load_value;
	logic [12:0] fetch_addr, fetch_addr_reduced;
	logic [6:0] addr = '0;
	logic [7:0] wdata = '0, rdata;
	int miscompares = 0, tests_run = 0;
	always #2 ref_clk = ~ref_clk;
	core_model core_model_inst (.ref_clk(ref_clk), .pc_advance(pc_advance),
		.pc_load(pc_load), .pc_load_value(pc_load_value), .int_accept(int_accept));
	memory_map_bank_decoder memory_map_bank_decoder_inst (.ref_clk(ref_clk), .rst(rst),
		.pc_advance(pc_advance), .pc_load(pc_load), .pc_load_value(pc_load_value),
		.int_accept(int_accept), .fetch_addr(fetch_addr), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	memory_map_bank_decoder #(.REDUCED(1'b1)) memory_map_bank_decoder_reduced_inst (
		.ref_clk(ref_clk), .rst(rst), .pc_advance(pc_advance), .pc_load(pc_load),
		.pc_load_value(pc_load_value), .int_accept(int_accept),
		.fetch_addr(fetch_addr_reduced), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata());
	task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge ref_clk);
		wr <= 0;
	endtask : wr_reg
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1;
		@(posedge ref_clk);
		rd <= 0;
		#1 check("rdata", {5'h00, exp}, {5'h00, rdata});
	endtask : rd_chk
	task automatic test_reset;
		#1 check("fetch_addr", RESET_VECTOR, fetch_addr);
		check("fetch_addr_reduced", RESET_VECTOR, fetch_addr_reduced);
		rd_chk(OFS_FLAGS, FLAGS_RESET);
	endtask : test_reset
	task automatic test_fetch;
		wr_reg(OFS_PC_HIGH_LATCH, 8'h18);
		core_model_inst.pulse(1, 11'h7ff);
		#1 check("fetch_addr", 13'h1fff, fetch_addr);
		check("fetch_addr_reduced", 13'h0fff, fetch_addr_reduced);
		core_model_inst.pulse(0, 11'h000);
		#1 check("fetch_addr", 13'h0000, fetch_addr);
		check("fetch_addr_reduced", 13'h0000, fetch_addr_reduced);
		core_model_inst.pulse(2, 11'h123);
		#1 check("fetch_addr", INT_VECTOR, fetch_addr);
		check("fetch_addr_reduced", INT_VECTOR, fetch_addr_reduced);
	endtask : test_fetch
	task automatic test_data;
		wr_reg(COMMON_LO, 8'ha5);
		wr_reg(OFS_FSR, 8'h75);
		wr_reg(GPR_LO, 8'h5a);
		for (int b = 1; b < 4; b++) begin
			wr_reg(OFS_FLAGS, {1'b0, 2'(b), 5'h18});
			rd_chk(COMMON_LO, 8'ha5);
			rd_chk(OFS_FSR, 8'h75);
			if (b == 1) wr_reg(GPR_LO, 8'h11);
			wr_reg(7'h40, {6'h10, 2'(b)});
		end
		for (int b = 1; b < 4; b++) begin
			wr_reg(OFS_FLAGS, {1'b0, 2'(b), 5'h18});
			if (b == 1) rd_chk(GPR_LO, 8'h11);
			rd_chk(7'h40, (b == 3) ? ZERO8 : {6'h10, 2'(b)});
		end
		wr_reg(OFS_FLAGS, FLAGS_RESET);
		rd_chk(GPR_LO, 8'h5a);
		wr_reg(OFS_INDIRECT, 8'h3c);
		rd_chk(7'h75, 8'h3c);
		rd_chk(OFS_INDIRECT, 8'h3c);
		wr_reg(7'h01, 8'hff);
		rd_chk(7'h01, ZERO8);
	endtask : test_data
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		test_reset();
		test_fetch();
		test_data();
		print_verdict();
	end
	initial begin
		#20000;
		miscompares++;
		print_verdict();
	end
endmodule : tb_top
